// ### logic/mmu_tlb_table_walk.sv
// translation unit: buffer, access check, table walk, program registers
// assumes core holds request until done; memory answers with mem_ack
//
// Summary of operation
// - sections of 1MB, small pages 4kB and large pages 64kB are mapped.
// - access control per 1kB small sub-page and 16kB large sub-page.
// - domain register holds sixteen 2-bit rights fields.
// - buffer holds 32 translations feeding the access check.
// - on hit, permitted access gets physical address, else abort.
// - on miss, walk the table in memory and load the buffer.
// - victim entry chosen round-robin.
// - translation off after reset; address passes through unchanged.
// - registers are 32 bits, reached by coprocessor transfers only.
// - table base is 16kB aligned; low 14 bits stored as zero.
// - fault status holds domain 7:4, type 3:1, external flag bit 0.
// - writing fault status location flushes the whole buffer.
// - fault address captures the faulting virtual address.
// - writing fault address location purges a matching entry only.
// - fault registers update on data faults, not prefetch faults.
// - first-level address is base 31:14 joined with address 31:20.
// - descriptor bit 1 separates section from page table.
// - sections end after level one; pages need a second fetch.
// - control bit 0 translation, bit 2 cache, bit 3 write buffer.
// - level one type 00 fault, 01 page, 10 section, 11 reserved.
`timescale 1ns/1ps
module mmu_tlb_table_walk #(
    parameter int ENTRIES = 32
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // coprocessor register transfers
    input  wire logic        cp_write,
    input  wire logic        cp_read,
    input  wire logic [3:0]  cp_index,
    input  wire logic [31:0] cp_wdata,
    output logic      [31:0] cp_rdata,
    // core access; ext_abort belongs to the walk memory port
    input  wire logic        req,
    input  wire logic [31:0] vaddr,
    input  wire logic        is_write,
    input  wire logic        is_user,
    input  wire logic        is_data,
    input  wire logic        ext_abort,
    output logic             done,
    output logic             abort,
    output logic [31:0]      paddr,
    // table walk memory port
    output logic             mem_req,
    output logic [31:0]      mem_addr,
    input  wire logic        mem_ack,
    input  wire logic [31:0] mem_rdata,
    // control outputs
    output logic             cache_on,
    output logic             wbuf_on
);
    localparam int IW = $clog2(ENTRIES);

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_l1   = 2'b01,
        st_l2   = 2'b10,
        st_resp = 2'b11
    } walk_t;

    typedef struct packed {
        walk_t                 state;
        logic [31:0]           control;
        logic [31:0]           table_base;
        logic [31:0]           domains;
        logic [7:0]            fault_cause;
        logic [31:0]           fault_vaddr;
        logic [ENTRIES-1:0]    valid;
        logic [ENTRIES*20-1:0] tags;
        logic [ENTRIES*2-1:0]  sizes;
        logic [ENTRIES*20-1:0] frames;
        logic [ENTRIES*4-1:0]  doms;
        logic [ENTRIES*8-1:0]  perms;
        logic [IW-1:0]         victim;
        logic [31:0]           l1_desc;
        logic [31:0]           cp_rdata;
        logic                  done;
        logic                  abort;
        logic [31:0]           paddr;
        logic                  mem_req;
        logic [31:0]           mem_addr;
    } state_t;

    state_t s_reg;
    state_t s_next;

    logic [ENTRIES-1:0] hit_vec;
    logic [ENTRIES-1:0] purge_vec;

    tlb_match #(.ENTRIES(ENTRIES)) u_look (
        .vaddr (vaddr),
        .valid (s_reg.valid),
        .tags  (s_reg.tags),
        .sizes (s_reg.sizes),
        .hit   (hit_vec)
    );

    tlb_match #(.ENTRIES(ENTRIES)) u_purge (
        .vaddr (cp_wdata),
        .valid (s_reg.valid),
        .tags  (s_reg.tags),
        .sizes (s_reg.sizes),
        .hit   (purge_vec)
    );

    // access check from domain rights and ap bits
    function automatic logic [3:0] check(input logic [1:0] rights,
                                         input logic [1:0] ap,
                                         input logic       wr,
                                         input logic       usr);
        logic ok;
        ok = 1'b0;
        unique case (ap)
            2'h0:    ok = 1'b0;
            2'h1:    ok = !usr;
            2'h2:    ok = !usr || !wr;
            default: ok = 1'b1;
        endcase
        if (rights == mmu_pkg::dom_manager) begin
            check = 4'h0;
        end else if (rights == mmu_pkg::dom_client) begin
            check = ok ? 4'h0 : {1'b1, mmu_pkg::fs_permission};
        end else begin
            check = {1'b1, mmu_pkg::fs_domain};
        end
    endfunction : check

    logic [IW-1:0] hit_idx;
    always_comb begin
        hit_idx = '0;
        for (int k = 0; k < ENTRIES; k++) begin
            if (hit_vec[k]) begin
                hit_idx = IW'(k);
            end
        end
    end

    // selected entry fields
    logic [19:0] e_frame;
    logic [1:0]  e_size;
    logic [3:0]  e_dom;
    logic [7:0]  e_perm;
    logic [1:0]  e_ap;
    logic [31:0] e_pa;
    assign e_frame = s_reg.frames[hit_idx*20 +: 20];
    assign e_size  = s_reg.sizes[hit_idx*2 +: 2];
    assign e_dom   = s_reg.doms[hit_idx*4 +: 4];
    assign e_perm  = s_reg.perms[hit_idx*8 +: 8];

    always_comb begin
        unique case (mmu_pkg::map_size_t'(e_size))
            mmu_pkg::map_section: begin
                e_ap = e_perm[1:0];
                e_pa = {e_frame[19:8], vaddr[mmu_pkg::section_shift-1:0]};
            end
            mmu_pkg::map_large: begin
                e_ap = e_perm[2*vaddr[15:14] +: 2];
                e_pa = {e_frame[19:4], vaddr[mmu_pkg::large_shift-1:0]};
            end
            default: begin
                e_ap = e_perm[2*vaddr[11:10] +: 2];
                e_pa = {e_frame, vaddr[mmu_pkg::small_shift-1:0]};
            end
        endcase
    end

    logic [3:0] e_chk;
    assign e_chk = check(s_reg.domains[2*e_dom +: 2], e_ap, is_write, is_user);

    // level one domain for page faults
    logic [3:0] l1_dom;
    assign l1_dom = s_reg.l1_desc[8:5];

    always_comb begin
        s_next         = s_reg;
        s_next.done    = 1'b0;
        s_next.abort   = 1'b0;
        s_next.cp_rdata = mmu_pkg::zero_word;

        // register transfers
        if (cp_read) begin
            unique case (cp_index)
                mmu_pkg::reg_fault_idx: s_next.cp_rdata = {24'h000000, s_reg.fault_cause};
                mmu_pkg::reg_faddr_idx: s_next.cp_rdata = s_reg.fault_vaddr;
                default:                s_next.cp_rdata = mmu_pkg::zero_word;
            endcase
        end
        if (cp_write) begin
            unique case (cp_index)
                mmu_pkg::reg_control_idx: s_next.control = cp_wdata;
                mmu_pkg::reg_table_idx:
                    s_next.table_base = {cp_wdata[31:mmu_pkg::table_align_bits], 14'h0000};
                mmu_pkg::reg_domain_idx: s_next.domains = cp_wdata;
                mmu_pkg::reg_fault_idx:  s_next.valid = '0;
                mmu_pkg::reg_faddr_idx:  s_next.valid = s_reg.valid & ~purge_vec;
                default: ;
            endcase
        end

        unique case (s_reg.state)
            st_idle: begin
                if (req) begin
                    if (!s_reg.control[mmu_pkg::ctl_mmu_bit]) begin
                        s_next.paddr = vaddr;
                        s_next.done  = 1'b1;
                        s_next.state = st_resp;
                    end else if (|hit_vec) begin
                        s_next.done  = 1'b1;
                        s_next.state = st_resp;
                        if (e_chk[3]) begin
                            s_next.abort = 1'b1;
                            if (is_data) begin
                                s_next.fault_cause = {e_dom, e_chk[2:0], 1'b0};
                                s_next.fault_vaddr = vaddr;
                            end
                        end else begin
                            s_next.paddr = e_pa;
                        end
                    end else begin
                        s_next.mem_addr = {s_reg.table_base[31:14], vaddr[31:20], 2'b00};
                        s_next.mem_req  = 1'b1;
                        s_next.state    = st_l1;
                    end
                end
            end
            st_l1: begin
                if (mem_ack) begin
                    s_next.mem_req = 1'b0;
                    s_next.l1_desc = mem_rdata;
                    if (ext_abort || !(mem_rdata[1] ^ mem_rdata[0])) begin
                        s_next.abort = 1'b1;
                        s_next.done  = 1'b1;
                        s_next.state = st_resp;
                        if (is_data) begin
                            s_next.fault_cause = {mem_rdata[8:5],
                                ext_abort ? 3'h0 : mmu_pkg::fs_xlate_section, ext_abort};
                            s_next.fault_vaddr = vaddr;
                        end
                    end else if (mem_rdata[1]) begin
                        s_next.valid[s_reg.victim]           = 1'b1;
                        s_next.tags[s_reg.victim*20 +: 20]   = vaddr[31:12];
                        s_next.sizes[s_reg.victim*2 +: 2]    = mmu_pkg::map_section;
                        s_next.frames[s_reg.victim*20 +: 20] = {mem_rdata[31:20], 8'h00};
                        s_next.doms[s_reg.victim*4 +: 4]     = mem_rdata[8:5];
                        s_next.perms[s_reg.victim*8 +: 8]    = {4{mem_rdata[11:10]}};
                        s_next.victim = s_reg.victim + IW'(1);
                        s_next.state  = st_idle;
                    end else begin
                        s_next.mem_addr = {mem_rdata[31:10], vaddr[19:12], 2'b00};
                        s_next.mem_req  = 1'b1;
                        s_next.state    = st_l2;
                    end
                end
            end
            st_l2: begin
                if (mem_ack) begin
                    s_next.mem_req = 1'b0;
                    if (ext_abort || !(mem_rdata[1] ^ mem_rdata[0])) begin
                        s_next.abort = 1'b1;
                        s_next.done  = 1'b1;
                        s_next.state = st_resp;
                        if (is_data) begin
                            s_next.fault_cause = {l1_dom,
                                ext_abort ? 3'h0 : mmu_pkg::fs_xlate_page, ext_abort};
                            s_next.fault_vaddr = vaddr;
                        end
                    end else begin
                        s_next.valid[s_reg.victim]           = 1'b1;
                        s_next.tags[s_reg.victim*20 +: 20]   = vaddr[31:12];
                        s_next.sizes[s_reg.victim*2 +: 2]    =
                            mem_rdata[0] ? mmu_pkg::map_large : mmu_pkg::map_small;
                        s_next.frames[s_reg.victim*20 +: 20] = mem_rdata[31:12];
                        s_next.doms[s_reg.victim*4 +: 4]     = l1_dom;
                        s_next.perms[s_reg.victim*8 +: 8]    = mem_rdata[11:4];
                        s_next.victim = s_reg.victim + IW'(1);
                        // lookup retried from idle; it now hits
                        s_next.state  = st_idle;
                    end
                end
            end
            st_resp: begin
                // one idle cycle lets the core drop its request
                s_next.state = st_idle;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_reg         <= '0;
            s_reg.control <= mmu_pkg::control_reset;
        end else begin
            s_reg <= s_next;
        end
    end

    assign cp_rdata = s_reg.cp_rdata;
    assign done     = s_reg.done;
    assign abort    = s_reg.abort;
    assign paddr    = s_reg.paddr;
    assign mem_req  = s_reg.mem_req;
    assign mem_addr = s_reg.mem_addr;
    assign cache_on = s_reg.control[mmu_pkg::ctl_cache_bit];
    assign wbuf_on  = s_reg.control[mmu_pkg::ctl_wbuf_bit];
endmodule : mmu_tlb_table_walk

// ### logic/mmu_pkg.sv
// constants and types for the translation unit
// assumes a coprocessor register port and a word-wide table walk port
package mmu_pkg;
    localparam logic [3:0]  reg_control_idx  = 4'h1;
    localparam logic [3:0]  reg_table_idx    = 4'h2;
    localparam logic [3:0]  reg_domain_idx   = 4'h3;
    localparam logic [3:0]  reg_fault_idx    = 4'h5;
    localparam logic [3:0]  reg_faddr_idx    = 4'h6;
    localparam int          ctl_mmu_bit      = 0;
    localparam int          ctl_cache_bit    = 2;
    localparam int          ctl_wbuf_bit     = 3;
    localparam logic [31:0] control_reset    = 32'h0000_0000;
    localparam logic [31:0] zero_word        = 32'h0000_0000;
    localparam int          table_align_bits = 14;
    localparam int          section_shift    = 20;
    localparam int          large_shift      = 16;
    localparam int          small_shift      = 12;
    localparam int          large_sub_shift  = 14;
    localparam int          small_sub_shift  = 10;
    localparam logic [1:0]  desc_fault       = 2'h0;
    localparam logic [1:0]  desc_page        = 2'h1;
    localparam logic [1:0]  desc_section     = 2'h2;
    localparam logic [1:0]  desc_reserved    = 2'h3;
    localparam logic [2:0]  fs_xlate_section = 3'h2;
    localparam logic [2:0]  fs_xlate_page    = 3'h3;
    localparam logic [2:0]  fs_domain        = 3'h4;
    localparam logic [2:0]  fs_permission    = 3'h6;
    localparam logic [1:0]  dom_none         = 2'h0;
    localparam logic [1:0]  dom_client       = 2'h1;
    localparam logic [1:0]  dom_manager      = 2'h3;
    // size of a mapping held in the buffer
    typedef enum logic [1:0] {
        map_section = 2'b00,
        map_large   = 2'b01,
        map_small   = 2'b10
    } map_size_t;
endpackage : mmu_pkg

// ### logic/tlb_match.sv
// one comparator per buffer entry, reduced to hit flags
// assumes entries are held by the caller in flat vectors
`timescale 1ns/1ps
module tlb_match #(
    parameter int ENTRIES = 32
) (
    // lookup
    input  wire logic [31:0]          vaddr,
    // entry state
    input  wire logic [ENTRIES-1:0]   valid,
    input  wire logic [ENTRIES*20-1:0] tags,
    input  wire logic [ENTRIES*2-1:0] sizes,
    // result
    output logic      [ENTRIES-1:0]   hit
);
    genvar i;
    generate
        for (i = 0; i < ENTRIES; i++) begin : g_cmp
            logic [19:0] t;
            logic [1:0]  s;
            assign t = tags[i*20 +: 20];
            assign s = sizes[i*2 +: 2];
            // tag compare width follows the mapping granularity
            always_comb begin
                unique case (s)
                    2'b00:   hit[i] = valid[i] && (t[19:8] == vaddr[31:20]);
                    2'b01:   hit[i] = valid[i] && (t[19:4] == vaddr[31:16]);
                    default: hit[i] = valid[i] && (t == vaddr[31:12]);
                endcase
            end
        end
    endgenerate
endmodule : tlb_match

// ### tb/mmu_tlb_table_walk_properties.sv
// port-level checker for the translation unit
// assumes one clock, synchronous reset; bound into every instance of the top
`timescale 1ns/1ps
module mmu_tlb_table_walk_properties #(
    parameter int ENTRIES = 32
) (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        rst,
    // register transfers
    input wire logic        cp_write,
    input wire logic        cp_read,
    input wire logic [3:0]  cp_index,
    input wire logic [31:0] cp_wdata,
    input wire logic [31:0] cp_rdata,
    // core access
    input wire logic        req,
    input wire logic [31:0] vaddr,
    input wire logic        done,
    input wire logic        abort,
    input wire logic [31:0] paddr,
    // walk port
    input wire logic        mem_req,
    input wire logic [31:0] mem_addr,
    input wire logic        mem_ack,
    input wire logic [31:0] mem_rdata,
    input wire logic        ext_abort,
    // control outputs
    input wire logic        cache_on,
    input wire logic        wbuf_on
);
    logic        mmu_on_reg;
    logic        next_l2_reg;
    logic [31:0] base_reg;
    logic [31:0] wdata_reg;

    // shadow of the programmed state, needed to predict walk addresses
    always_ff @(posedge ref_clk) begin
        wdata_reg <= cp_wdata;
        if (rst) begin
            mmu_on_reg  <= 1'b0;
            next_l2_reg <= 1'b0;
            base_reg    <= 32'h0000_0000;
        end else begin
            if (cp_write && cp_index == mmu_pkg::reg_control_idx) begin
                mmu_on_reg <= cp_wdata[mmu_pkg::ctl_mmu_bit];
            end
            if (cp_write && cp_index == mmu_pkg::reg_table_idx) begin
                base_reg <= cp_wdata;
            end
            if (mem_req && mem_ack) begin
                next_l2_reg <= !next_l2_reg && !ext_abort && mem_rdata[1:0] == mmu_pkg::desc_page;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    AST_PASS_THROUGH: assert property (
        $rose(req) && !mmu_on_reg |=> done && !abort && paddr == $past(vaddr))
        else $error("pass-through answer wrong");
    AST_NO_WALK_OFF: assert property (mem_req |-> mmu_on_reg)
        else $error("walk while translation off");
    AST_L1_ADDR: assert property (
        $rose(mem_req) && !next_l2_reg |-> mem_addr == {base_reg[31:14], vaddr[31:20], 2'h0})
        else $error("first-level fetch address wrong");
    AST_MEM_HOLD: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("walk request dropped early");
    AST_DONE_PULSE: assert property (done |=> !done)
        else $error("done longer than one cycle");
    AST_DONE_CAUSE: assert property (done |-> $past(req))
        else $error("done without request");
    AST_ABORT_DONE: assert property (abort |-> done)
        else $error("abort without done");
    AST_CONTROL_BITS: assert property (
        cp_write && cp_index == mmu_pkg::reg_control_idx |=>
        cache_on == wdata_reg[mmu_pkg::ctl_cache_bit] && wbuf_on == wdata_reg[mmu_pkg::ctl_wbuf_bit])
        else $error("control outputs wrong");
    AST_READ_ZERO: assert property (
        !(cp_read && (cp_index == mmu_pkg::reg_fault_idx || cp_index == mmu_pkg::reg_faddr_idx))
        |=> cp_rdata == mmu_pkg::zero_word)
        else $error("read data not zero");
    AST_STATUS_FORMAT: assert property (
        cp_read && cp_index == mmu_pkg::reg_fault_idx |=> cp_rdata[31:8] == 24'h0)
        else $error("fault status upper bits set");
    AST_RESET_OUT: assert property ($fell(rst) |-> !done && !mem_req && !cache_on && !wbuf_on)
        else $error("outputs not cleared by reset");

    COV_PASS: cover property ($rose(req) && !mmu_on_reg ##1 done);
    COV_WALK: cover property (mem_req && mem_ack);
    COV_L2: cover property (mem_ack && next_l2_reg);
    COV_ABORT: cover property (abort);
endmodule : mmu_tlb_table_walk_properties

bind mmu_tlb_table_walk mmu_tlb_table_walk_properties #(.ENTRIES(ENTRIES)) i_props (
    .ref_clk(ref_clk), .rst(rst), .cp_write(cp_write), .cp_read(cp_read),
    .cp_index(cp_index), .cp_wdata(cp_wdata), .cp_rdata(cp_rdata), .req(req),
    .vaddr(vaddr), .done(done), .abort(abort), .paddr(paddr), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .ext_abort(ext_abort), .cache_on(cache_on), .wbuf_on(wbuf_on));

// ### tb/walk_mem_model.sv
// behavioural table memory on the walk port
// assumes requests held until acknowledged; answers at the falling edge
`timescale 1ns/1ps
module walk_mem_model (
    // clock
    input wire logic         ref_clk,
    // walk port
    input wire logic         mem_req,
    input wire logic [31:0]  mem_addr,
    output logic             mem_ack,
    output logic [31:0]      mem_rdata,
    output logic             ext_abort
);
    logic [31:0] store [logic [31:0]];
    logic [31:0] dflt = 32'h0000_0000;
    logic [31:0] last_addr = 32'h0000_0000;
    logic [31:0] last_data = 32'h0000_0000;
    logic        fail_next = 1'b0;
    int          lat = 0;
    int          wait_cnt = 0;
    int          n_fetch = 0;

    initial begin
        mem_ack = 1'b0;
        ext_abort = 1'b0;
        mem_rdata = 32'hFFFF_FFFF;
    end

    // idle bus shows the inverse of the last word so stale data cannot pass
    always @(negedge ref_clk) begin
        mem_ack = 1'b0;
        ext_abort = 1'b0;
        mem_rdata = ~last_data;
        if (!mem_req) begin
            wait_cnt = 0;
        end else if (wait_cnt < lat) begin
            wait_cnt++;
        end else begin
            last_data = store.exists(mem_addr) ? store[mem_addr] : dflt;
            last_addr = mem_addr;
            mem_ack = 1'b1;
            mem_rdata = last_data;
            ext_abort = fail_next;
            fail_next = 1'b0;
            wait_cnt = 0;
            n_fetch++;
        end
    end
endmodule : walk_mem_model

// ### tb/mmu_tlb_table_walk_test.sv
// self-checking bench for the translation unit
// assumes the walk memory model; inputs move at falling edges
`timescale 1ns/1ps
module mmu_tlb_table_walk_test;
    localparam int          NENT = 4;
    localparam logic [31:0] BASE = 32'h1234_7ABC;
    logic        ref_clk, rst, cp_write, cp_read, req, is_write, is_user, is_data;
    logic [3:0]  cp_index;
    logic [31:0] cp_wdata, cp_rdata, vaddr, paddr, mem_addr, mem_rdata, v;
    logic        done, abort, mem_req, mem_ack, ext_abort, cache_on, wbuf_on;
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          cycles = 0;
    int          f0;
    int          order [8] = '{0, 1, 2, 3, 4, 2, 0, 1};
    int          fcnt  [8] = '{1, 2, 3, 4, 5, 5, 6, 7};

    // four entries so that replacement wraps within a short run
    mmu_tlb_table_walk #(.ENTRIES(NENT)) i_dut (
        .ref_clk(ref_clk), .rst(rst), .cp_write(cp_write), .cp_read(cp_read),
        .cp_index(cp_index), .cp_wdata(cp_wdata), .cp_rdata(cp_rdata), .req(req),
        .vaddr(vaddr), .is_write(is_write), .is_user(is_user), .is_data(is_data),
        .ext_abort(ext_abort), .done(done), .abort(abort), .paddr(paddr),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .cache_on(cache_on), .wbuf_on(wbuf_on));
    walk_mem_model i_mem (
        .ref_clk(ref_clk), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .ext_abort(ext_abort));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            finish_test();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic cp_wr(input logic [3:0] idx, input logic [31:0] d);
        @(negedge ref_clk);
        cp_write = 1'b1;
        cp_index = idx;
        cp_wdata = d;
        @(negedge ref_clk);
        cp_write = 1'b0;
    endtask : cp_wr

    task automatic cp_rd(input logic [3:0] idx, output logic [31:0] d);
        @(negedge ref_clk);
        cp_read = 1'b1;
        cp_index = idx;
        @(negedge ref_clk);
        cp_read = 1'b0;
        d = cp_rdata;
    endtask : cp_rd

    // user accesses are writes, supervisor accesses reads
    task automatic access(input logic [31:0] va, input logic dat, input logic usr,
                          input logic exp_ab, input logic [31:0] exp_pa);
        int n;
        @(negedge ref_clk);
        req = 1'b1;
        vaddr = va;
        is_data = dat;
        is_user = usr;
        is_write = usr;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (done !== 1'b1 && n < 200);
        req = 1'b0;
        chk("done", 32'h1, {31'h0, done});
        chk("abort", {31'h0, exp_ab}, {31'h0, abort});
        if (!exp_ab) chk("paddr", exp_pa, paddr);
    endtask : access

    function automatic logic [31:0] l1a(input logic [31:0] va);
        return {BASE[31:14], va[31:20], 2'h0};
    endfunction : l1a

    function automatic logic [31:0] sect(input logic [11:0] pa, input logic [1:0] ap,
                                         input logic [3:0] dm);
        return {pa, 8'h00, ap, 1'b0, dm, 3'b100, mmu_pkg::desc_section};
    endfunction : sect

    task automatic sec(input int k, input int f);
        logic [31:0] va;
        va = {12'h001 + k[11:0], 20'h00ABC};
        i_mem.lat = k[0] ? 3 : 0;
        access(va, 1'b1, 1'b0, 1'b0, {12'hA00 + k[11:0], va[19:0]});
        chk("fetches", 32'(f), 32'(i_mem.n_fetch));
    endtask : sec

    task automatic fault_is(input logic [31:0] exp);
        cp_rd(mmu_pkg::reg_fault_idx, v);
        chk("fault status", exp, v);
    endtask : fault_is

    initial begin
        {rst, cp_write, cp_read, req, is_write, is_user, is_data} = 7'h40;
        cp_index = 4'h0;
        cp_wdata = 32'h0;
        vaddr = 32'h0;
        repeat (6) @(negedge ref_clk);
        rst = 1'b0;
        access(32'h8765_4321, 1'b1, 1'b0, 1'b0, 32'h8765_4321);
        chk("fetches off", 32'h0, 32'(i_mem.n_fetch));
        cp_rd(mmu_pkg::reg_control_idx, v);
        chk("control read", mmu_pkg::zero_word, v);
        $display("test pass_through done");
        cp_wr(mmu_pkg::reg_table_idx, BASE);
        cp_wr(mmu_pkg::reg_domain_idx, 32'hFFFF_FF37);
        cp_wr(mmu_pkg::reg_control_idx, 32'h0000_000D);
        chk("cache wbuf", 32'h3, {30'h0, wbuf_on, cache_on});
        for (int k = 0; k < 5; k++) begin
            i_mem.store[l1a({12'h001 + 12'(k), 20'h0})] = sect(12'hA00 + 12'(k), 2'h3, 4'h0);
        end
        for (int i = 0; i < 8; i++) sec(order[i], fcnt[i]);
        chk("walk addr", l1a(32'h0020_0000), i_mem.last_addr);
        cp_wr(mmu_pkg::reg_faddr_idx, 32'h0040_0000);
        sec(4, 7);
        sec(3, 8);
        cp_wr(mmu_pkg::reg_fault_idx, 32'hFFFF_FFFF);
        sec(4, 9);
        chk("cache wbuf kept", 32'h3, {30'h0, wbuf_on, cache_on});
        $display("test replacement done");
        i_mem.store[l1a(32'h0120_0000)] = sect(12'hB00, 2'h3, 4'h3);
        i_mem.store[l1a(32'h0130_0000)] = sect(12'hB01, 2'h0, 4'h1);
        i_mem.store[l1a(32'h0140_0000)] = sect(12'hB02, 2'h3, 4'h1);
        i_mem.store[l1a(32'h0150_0000)] = 32'h3;
        access(32'h0100_0040, 1'b1, 1'b0, 1'b1, 32'h0);
        fault_is({28'h0, mmu_pkg::fs_xlate_section, 1'b0});
        cp_rd(mmu_pkg::reg_faddr_idx, v);
        chk("fault addr", 32'h0100_0040, v);
        access(32'h0110_0080, 1'b0, 1'b0, 1'b1, 32'h0);
        fault_is({28'h0, mmu_pkg::fs_xlate_section, 1'b0});
        cp_rd(mmu_pkg::reg_faddr_idx, v);
        chk("fault addr kept", 32'h0100_0040, v);
        access(32'h0120_0000, 1'b1, 1'b0, 1'b1, 32'h0);
        fault_is({24'h0, 4'h3, mmu_pkg::fs_domain, 1'b0});
        access(32'h0130_0010, 1'b1, 1'b1, 1'b1, 32'h0);
        fault_is({24'h0, 4'h1, mmu_pkg::fs_permission, 1'b0});
        access(32'h0140_0020, 1'b1, 1'b1, 1'b0, 32'hB020_0020);
        access(32'h0150_0000, 1'b1, 1'b0, 1'b1, 32'h0);
        $display("test faults done");
        i_mem.store[l1a(32'h0160_0000)] = 32'h0002_0031;
        i_mem.dflt = 32'hC0DE_5F32;
        f0 = i_mem.n_fetch;
        access(32'h0160_5078, 1'b1, 1'b1, 1'b0, 32'hC0DE_5078);
        chk("page fetches", 32'(f0 + 2), 32'(i_mem.n_fetch));
        access(32'h0160_5478, 1'b1, 1'b1, 1'b1, 32'h0);
        access(32'h0160_5878, 1'b1, 1'b1, 1'b0, 32'hC0DE_5878);
        chk("page hits", 32'(f0 + 2), 32'(i_mem.n_fetch));
        i_mem.store[l1a(32'h0170_0000)] = 32'h0002_0011;
        i_mem.dflt = 32'hD000_0FF1;
        access(32'h0170_9ABC, 1'b1, 1'b0, 1'b0, 32'hD000_9ABC);
        i_mem.fail_next = 1'b1;
        access(32'h0190_0000, 1'b1, 1'b0, 1'b1, 32'h0);
        cp_rd(mmu_pkg::reg_fault_idx, v);
        chk("external flag", 32'h1, {28'h0, v[3:0]});
        $display("test pages done");
        finish_test();
    end
endmodule : mmu_tlb_table_walk_test
